// >>> common/apcd_pkg.sv
// Purpose: constants and carriers for the audio port clock/direction control
// Assumes: 8-bit registers on a simple parallel control port, byte addressed
// Notes: field positions and reset values are kept here; the checks and the bench repeat them as literals
//
// Notes on behaviour
// - serial data output pin is driven only while its enable bit 5 is 1.
// - mute request reaches power stage only while forward bit 4 is 1.
// - polarity 1 aligns frame/data edges to bit-clock rising edges, 0 to falling.
// - bit-clock output enable bit 4 makes the port master, else bit clock input.
// - master bit clock is the master clock divided by a programmable factor.
// - frame-clock output enable bit 0 drives the frame pin, else it is input.
// - master frame clock is the bit clock divided down to the sample rate.
// - bit-clock divider held reset while its run bit 1 is 0; resets to 0.
// - frame divider held reset while its run bit 0 is 0; resets to 1.
// - multiplier reference is master clock (0) or bit clock (1); auto mode overrides.
// - processing clock source from bits 2..0; codes above 101 mute the clock.
package apcd_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] APCD_OFS_PIN_OE = 8'h08;
   localparam logic [7:0] APCD_OFS_PORT_CTRL = 8'h09;
   localparam logic [7:0] APCD_OFS_DIV_RUN = 8'h0C;
   localparam logic [7:0] APCD_OFS_CLK_SRC = 8'h0D;

   localparam int APCD_SDO_OE_BIT = 5;
   localparam int APCD_MUTE_FWD_BIT = 4;
   localparam int APCD_BCLK_POL_BIT = 5;
   localparam int APCD_BCLK_OE_BIT = 4;
   localparam int APCD_FRAME_OE_BIT = 0;
   localparam int APCD_BCLK_RUN_BIT = 1;
   localparam int APCD_FRAME_RUN_BIT = 0;
   localparam int APCD_REF_SEL_BIT = 4;
   localparam int APCD_SRC_LSB = 0;
   localparam int APCD_SRC_W = 3;

   localparam logic [7:0] APCD_RST_PIN_OE = 8'h00;
   localparam logic [7:0] APCD_RST_PORT_CTRL = 8'h00;
   localparam logic [7:0] APCD_RST_DIV_RUN = 8'h01;
   localparam logic [7:0] APCD_RST_CLK_SRC = 8'h00;

   // writable masks: reserved bits read as zero
   localparam logic [7:0] APCD_MSK_PIN_OE = 8'h30;
   localparam logic [7:0] APCD_MSK_PORT_CTRL = 8'h31;
   localparam logic [7:0] APCD_MSK_DIV_RUN = 8'h03;
   localparam logic [7:0] APCD_MSK_CLK_SRC = 8'h17;

   // highest legal processing clock source code (general pin)
   localparam logic [2:0] APCD_SRC_LAST = 3'h5;

   // divider defaults: half periods minus one
   localparam int APCD_BCLK_HALF_DEF = 1;
   localparam int APCD_FRAME_HALF_DEF = 31;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } apcd_req_t;

   typedef struct packed {
      logic rvalid;
      logic [7:0] rdata;
   } apcd_rsp_t;
endpackage

// >>> rtl/apcd_top.sv
// Purpose: serial audio port pin direction, mute forward and master clock dividers
// Assumes: CLK is the master clock; link pins are asynchronous to it
// Notes: received words pass a two-entry buffer before OUT_VALID/OUT_READY
`timescale 1ns/1ps
module apcd_top import apcd_pkg::*; #(
   parameter int DATA_W = 32,
   parameter int BDIV_W = 8,
   parameter int FDIV_W = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire apcd_req_t REQ,
   output apcd_rsp_t RSP,
   input wire logic [BDIV_W-1:0] BCLK_HALF,
   input wire logic [FDIV_W-1:0] FRAME_HALF,
   input wire logic AUTO_CLK_MODE,
   input wire logic MUTE_REQ,
   output logic PA_MUTE,
   input wire logic BCLK_I,
   output logic BCLK_O,
   output logic BCLK_OE,
   input wire logic LRCK_I,
   output logic LRCK_O,
   output logic LRCK_OE,
   input wire logic DIN,
   input wire logic SDO_I,
   output logic SDO_O,
   output logic SDO_OE,
   output logic PLL_REF_BCLK,
   output logic [2:0] PROC_CLK_SRC,
   output logic PROC_CLK_MUTED,
   output logic OUT_VALID,
   output logic [DATA_W-1:0] OUT_DATA,
   input wire logic OUT_READY,
   output logic RX_OVERRUN
);
   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic [7:0] pin_oe_reg, pin_oe_next;
   logic [7:0] port_ctrl_reg, port_ctrl_next;
   logic [7:0] div_run_reg, div_run_next;
   logic [7:0] clk_src_reg, clk_src_next;
   apcd_rsp_t rsp_reg, rsp_next;

   always_comb begin
      pin_oe_next = pin_oe_reg;
      port_ctrl_next = port_ctrl_reg;
      div_run_next = div_run_reg;
      clk_src_next = clk_src_reg;
      rsp_next = '0;
      if (REQ.wr) begin
         unique case (REQ.addr)
            APCD_OFS_PIN_OE: pin_oe_next = REQ.wdata & APCD_MSK_PIN_OE;
            APCD_OFS_PORT_CTRL: port_ctrl_next = REQ.wdata & APCD_MSK_PORT_CTRL;
            APCD_OFS_DIV_RUN: div_run_next = REQ.wdata & APCD_MSK_DIV_RUN;
            APCD_OFS_CLK_SRC: clk_src_next = REQ.wdata & APCD_MSK_CLK_SRC;
            default: ;
         endcase
      end
      if (REQ.rd) begin
         rsp_next.rvalid = 1'b1;
         unique case (REQ.addr)
            APCD_OFS_PIN_OE: rsp_next.rdata = pin_oe_reg;
            APCD_OFS_PORT_CTRL: rsp_next.rdata = port_ctrl_reg;
            APCD_OFS_DIV_RUN: rsp_next.rdata = div_run_reg;
            APCD_OFS_CLK_SRC: rsp_next.rdata = clk_src_reg;
            default: rsp_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pin_oe_reg <= APCD_RST_PIN_OE;
         port_ctrl_reg <= APCD_RST_PORT_CTRL;
         div_run_reg <= APCD_RST_DIV_RUN;
         clk_src_reg <= APCD_RST_CLK_SRC;
         rsp_reg <= '0;
      end else if (CE) begin
         pin_oe_reg <= pin_oe_next;
         port_ctrl_reg <= port_ctrl_next;
         div_run_reg <= div_run_next;
         clk_src_reg <= clk_src_next;
         rsp_reg <= rsp_next;
      end
   end

   // settings seen by the logic from the cycle after a write
   logic pol, bclk_master, frame_master, bclk_run, frame_run;
   assign pol = port_ctrl_reg[APCD_BCLK_POL_BIT];
   assign bclk_master = port_ctrl_reg[APCD_BCLK_OE_BIT];
   assign frame_master = port_ctrl_reg[APCD_FRAME_OE_BIT];
   assign bclk_run = div_run_reg[APCD_BCLK_RUN_BIT];
   assign frame_run = div_run_reg[APCD_FRAME_RUN_BIT];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] bclk_sync_reg, bclk_sync_next;
   logic [2:0] lrck_sync_reg, lrck_sync_next;
   logic [1:0] din_sync_reg, din_sync_next;

   always_comb begin
      // stage 0 only feeds stage 1; stage 2 is edge history
      bclk_sync_next = {bclk_sync_reg[1:0], BCLK_I};
      lrck_sync_next = {lrck_sync_reg[1:0], LRCK_I};
      din_sync_next = {din_sync_reg[0], DIN};
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bclk_sync_reg <= '0;
         lrck_sync_reg <= '0;
         din_sync_reg <= '0;
      end else if (CE) begin
         bclk_sync_reg <= bclk_sync_next;
         lrck_sync_reg <= lrck_sync_next;
         din_sync_reg <= din_sync_next;
      end
   end

   // ----------------------------------------------------------------
   // master clock dividers
   // ----------------------------------------------------------------
   logic [BDIV_W-1:0] bcnt_reg, bcnt_next;
   logic [FDIV_W-1:0] fcnt_reg, fcnt_next;
   logic bclk_reg, bclk_next;
   logic lrck_reg, lrck_next;
   logic btick_rise, btick_fall;

   always_comb begin
      bcnt_next = bcnt_reg;
      bclk_next = bclk_reg;
      fcnt_next = fcnt_reg;
      lrck_next = lrck_reg;
      btick_rise = 1'b0;
      btick_fall = 1'b0;
      if (!bclk_run) begin
         bcnt_next = '0;
         bclk_next = 1'b0;
      end else if (bcnt_reg >= BCLK_HALF) begin
         bcnt_next = '0;
         bclk_next = ~bclk_reg;
         btick_rise = ~bclk_reg;
         btick_fall = bclk_reg;
      end else begin
         bcnt_next = bcnt_reg + 1'b1;
      end
      // frame edges land on the falling bit-clock edge of the divider
      if (!frame_run) begin
         fcnt_next = '0;
         lrck_next = 1'b0;
      end else if (btick_fall) begin
         if (fcnt_reg >= FRAME_HALF) begin
            fcnt_next = '0;
            lrck_next = ~lrck_reg;
         end else begin
            fcnt_next = fcnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bcnt_reg <= '0;
         bclk_reg <= 1'b0;
         fcnt_reg <= '0;
         lrck_reg <= 1'b0;
      end else if (CE) begin
         bcnt_reg <= bcnt_next;
         bclk_reg <= bclk_next;
         fcnt_reg <= fcnt_next;
         lrck_reg <= lrck_next;
      end
   end

   // ----------------------------------------------------------------
   // receive deserializer
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] shift_reg, shift_next;
   logic last_frame_reg, last_frame_next;
   logic sample, frame_lvl, push;
   logic [DATA_W-1:0] push_word;

   always_comb begin
      // in master mode the source follows our clocks; the bit-clock pin is not sampled
      if (bclk_master) begin
         sample = btick_rise;
      end else if (pol) begin
         sample = ~bclk_sync_reg[1] & bclk_sync_reg[2];
      end else begin
         sample = bclk_sync_reg[1] & ~bclk_sync_reg[2];
      end
      frame_lvl = frame_master ? lrck_reg : lrck_sync_reg[1];
      shift_next = shift_reg;
      last_frame_next = last_frame_reg;
      push = 1'b0;
      push_word = shift_reg;
      if (sample) begin
         last_frame_next = frame_lvl;
         shift_next = {shift_reg[DATA_W-2:0], din_sync_reg[1]};
         // frame level change closes the word gathered so far
         if (frame_lvl != last_frame_reg) begin
            push = 1'b1;
            shift_next = {{(DATA_W-1){1'b0}}, din_sync_reg[1]};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         shift_reg <= '0;
         last_frame_reg <= 1'b0;
      end else if (CE) begin
         shift_reg <= shift_next;
         last_frame_reg <= last_frame_next;
      end
   end

   // ----------------------------------------------------------------
   // two-entry output buffer
   // ----------------------------------------------------------------
   logic head_v_reg, head_v_next, skid_v_reg, skid_v_next;
   logic [DATA_W-1:0] head_d_reg, head_d_next, skid_d_reg, skid_d_next;
   logic ovr_reg, ovr_next, in_ready;

   always_comb begin
      // serial link cannot be stalled, so a full buffer drops and flags
      in_ready = ~skid_v_reg;
      head_v_next = head_v_reg;
      head_d_next = head_d_reg;
      skid_v_next = skid_v_reg;
      skid_d_next = skid_d_reg;
      ovr_next = push & ~in_ready;
      if (head_v_reg && OUT_READY) begin
         head_v_next = 1'b0;
      end
      if (!head_v_next && skid_v_reg) begin
         head_v_next = 1'b1;
         head_d_next = skid_d_reg;
         skid_v_next = 1'b0;
      end
      if (push && in_ready) begin
         if (!head_v_next) begin
            head_v_next = 1'b1;
            head_d_next = push_word;
         end else begin
            skid_v_next = 1'b1;
            skid_d_next = push_word;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         head_v_reg <= 1'b0;
         head_d_reg <= '0;
         skid_v_reg <= 1'b0;
         skid_d_reg <= '0;
         ovr_reg <= 1'b0;
      end else if (CE) begin
         head_v_reg <= head_v_next;
         head_d_reg <= head_d_next;
         skid_v_reg <= skid_v_next;
         skid_d_reg <= skid_d_next;
         ovr_reg <= ovr_next;
      end
   end

   // ----------------------------------------------------------------
   // pin and clock-select outputs
   // ----------------------------------------------------------------
   logic pa_mute_reg, pa_mute_next;
   logic bclk_o_reg, bclk_o_next, bclk_oe_reg, bclk_oe_next;
   logic lrck_o_reg, lrck_o_next, lrck_oe_reg, lrck_oe_next;
   logic sdo_o_reg, sdo_o_next, sdo_oe_reg, sdo_oe_next;
   logic ref_reg, ref_next, muted_reg, muted_next;
   logic [2:0] src_reg, src_next;

   always_comb begin
      pa_mute_next = MUTE_REQ & pin_oe_next[APCD_MUTE_FWD_BIT];
      sdo_oe_next = pin_oe_next[APCD_SDO_OE_BIT];
      sdo_o_next = din_sync_reg[1] & sdo_oe_next;
      // pin edge follows polarity: inverted mode moves frame edges to rising
      bclk_oe_next = port_ctrl_next[APCD_BCLK_OE_BIT];
      bclk_o_next = (bclk_next ^ port_ctrl_next[APCD_BCLK_POL_BIT]) & bclk_oe_next;
      lrck_oe_next = port_ctrl_next[APCD_FRAME_OE_BIT];
      lrck_o_next = lrck_next & lrck_oe_next;
      ref_next = clk_src_next[APCD_REF_SEL_BIT] & ~AUTO_CLK_MODE;
      src_next = clk_src_next[APCD_SRC_LSB +: APCD_SRC_W];
      muted_next = src_next > APCD_SRC_LAST;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pa_mute_reg <= 1'b0;
         sdo_o_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
         bclk_o_reg <= 1'b0;
         bclk_oe_reg <= 1'b0;
         lrck_o_reg <= 1'b0;
         lrck_oe_reg <= 1'b0;
         ref_reg <= 1'b0;
         src_reg <= 3'h0;
         muted_reg <= 1'b0;
      end else if (CE) begin
         pa_mute_reg <= pa_mute_next;
         sdo_o_reg <= sdo_o_next;
         sdo_oe_reg <= sdo_oe_next;
         bclk_o_reg <= bclk_o_next;
         bclk_oe_reg <= bclk_oe_next;
         lrck_o_reg <= lrck_o_next;
         lrck_oe_reg <= lrck_oe_next;
         ref_reg <= ref_next;
         src_reg <= src_next;
         muted_reg <= muted_next;
      end
   end

   assign RSP = rsp_reg;
   assign PA_MUTE = pa_mute_reg;
   assign SDO_O = sdo_o_reg;
   assign SDO_OE = sdo_oe_reg;
   assign BCLK_O = bclk_o_reg;
   assign BCLK_OE = bclk_oe_reg;
   assign LRCK_O = lrck_o_reg;
   assign LRCK_OE = lrck_oe_reg;
   assign PLL_REF_BCLK = ref_reg;
   assign PROC_CLK_SRC = src_reg;
   assign PROC_CLK_MUTED = muted_reg;
   assign OUT_VALID = head_v_reg;
   assign OUT_DATA = head_d_reg;
   assign RX_OVERRUN = ovr_reg;
endmodule

// >>> dv/apcd_source_model.sv
// Purpose: external audio source on the serial link, master-mode timing
// Assumes: bit-clock polarity 0, word fills one frame half of 32 bit clocks
// Notes: never drives the clock lines, only the data line
`timescale 1ns/1ps
module apcd_source_model #(
   parameter logic [31:0] WORD = 32'hA5C3_0F96
) (
   input wire logic BCLK,
   input wire logic LRCK,
   output logic DIN
);
   logic [4:0] idx = 5'h00;
   logic last_lrck = 1'b0;
   initial DIN = 1'b0;
   // ------------------------------------------------------------
   // data launch
   // ------------------------------------------------------------
   // small delay so the frame level seen is the settled one
   always begin
      @(negedge BCLK);
      #1;
      if (LRCK !== last_lrck) begin
         DIN = WORD[31];
         idx = 5'h1E;
      end else begin
         DIN = WORD[idx];
         idx = idx - 5'h01;
      end
      last_lrck = LRCK;
   end
endmodule

// >>> dv/apcd_props.sv
// Purpose: port-level checks for the audio port control block
// Assumes: CE held high by the bench
// Notes: bound from the bench top
`timescale 1ns/1ps
module apcd_props import apcd_pkg::*; #(
   parameter int DATA_W = 32
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire apcd_req_t REQ,
   input wire apcd_rsp_t RSP,
   input wire logic AUTO_CLK_MODE,
   input wire logic MUTE_REQ,
   input wire logic PA_MUTE,
   input wire logic BCLK_OE,
   input wire logic LRCK_OE,
   input wire logic SDO_O,
   input wire logic SDO_OE,
   input wire logic PLL_REF_BCLK,
   input wire logic [2:0] PROC_CLK_SRC,
   input wire logic PROC_CLK_MUTED,
   input wire logic OUT_VALID,
   input wire logic [DATA_W-1:0] OUT_DATA,
   input wire logic OUT_READY,
   input wire logic DIN
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence wr_s(logic [7:0] a);
      CE && REQ.wr && REQ.addr == a;
   endsequence
   sequence rd_s;
      CE && REQ.rd;
   endsequence
   read_answer_a: assert property (rd_s |=> RSP.rvalid)
      else $error("read not answered");
   idle_rdata_a: assert property (!RSP.rvalid |-> RSP.rdata == 8'h00)
      else $error("rdata not zero when idle");
   sdo_dir_a: assert property (wr_s(8'h08) |=> SDO_OE == $past(REQ.wdata[5]))
      else $error("data pin direction wrong");
   sdo_idle_a: assert property (!SDO_OE |-> !SDO_O)
      else $error("data pin driven while input");
   sdo_echo_a: assert property (SDO_OE |-> SDO_O == $past(DIN, 3))
      else $error("data pin echo wrong");
   mute_fwd_a: assert property (PA_MUTE |-> $past(MUTE_REQ))
      else $error("mute without request");
   port_dir_a: assert property (wr_s(8'h09) |=>
      BCLK_OE == $past(REQ.wdata[4]) && LRCK_OE == $past(REQ.wdata[0]))
      else $error("clock pin direction wrong");
   ref_sel_a: assert property (wr_s(8'h0D) && !AUTO_CLK_MODE |=>
      PLL_REF_BCLK == $past(REQ.wdata[4]))
      else $error("reference select wrong");
   auto_ref_a: assert property (AUTO_CLK_MODE |=> !PLL_REF_BCLK)
      else $error("auto mode not overriding");
   src_code_a: assert property (wr_s(8'h0D) |=> PROC_CLK_SRC == $past(REQ.wdata[2:0]))
      else $error("clock source code wrong");
   src_mute_a: assert property (PROC_CLK_MUTED == (PROC_CLK_SRC > APCD_SRC_LAST))
      else $error("clock mute flag wrong");
   word_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
      else $error("word lost while stalled");
endmodule

// >>> dv/apcd_tb_top.sv
// Purpose: self-checking bench for the audio port control block
// Assumes: source model on the link; bench makes the slave clocks, still outside runs
// Notes: one task per scenario
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   $display("ERROR %s exp %0h got %0h", nm, exp, got); fail_count++; end end
module apcd_tb_top import apcd_pkg::*; ;
   localparam logic [31:0] WORD = 32'hA5C3_0F96;
   logic clk = 1'b0, rst = 1'b1, auto_mode = 1'b0, mute_req = 1'b0, out_ready = 1'b0;
   logic [7:0] bclk_half = 8'h03, frame_half = 8'h1F;
   apcd_req_t req = '0;
   apcd_rsp_t rsp;
   logic pa_mute, bclk_o, bclk_oe, lrck_o, lrck_oe, din, sdo_o, sdo_oe, ref_bclk;
   logic muted, out_valid, overrun;
   logic [2:0] src;
   logic [31:0] out_data;
   int fail_count = 0, cmp_count = 0, n;
   logic s_run = 1'b0, s_bclk = 1'b0, s_lrck = 1'b0, s_pol = 1'b0;
   logic bclk_pin, src_bclk, src_lrck;
   int s_div = 0, s_fall = 0;
   always #2.5 clk = ~clk;
   // shared pins: driving side wins; slave bit clock inverted for polarity 1
   assign src_bclk = bclk_oe ? bclk_o : s_bclk;
   assign src_lrck = lrck_oe ? lrck_o : s_lrck;
   assign bclk_pin = bclk_oe ? bclk_o : s_bclk ^ s_pol;
   // far-side clocks for slave runs; frame edges on bit-clock falls
   always @(posedge clk) begin
      #1;
      if (s_run) begin
         s_div++;
         if (s_div % 4 == 0) begin
            s_bclk = ~s_bclk;
            if (!s_bclk) begin
               s_fall++;
               if (s_fall % 32 == 0) begin
                  s_lrck = ~s_lrck;
               end
            end
         end
      end
   end
   apcd_top apcd_top_i (.CLK(clk), .RST(rst), .CE(1'b1), .REQ(req), .RSP(rsp),
      .BCLK_HALF(bclk_half), .FRAME_HALF(frame_half), .AUTO_CLK_MODE(auto_mode),
      .MUTE_REQ(mute_req), .PA_MUTE(pa_mute), .BCLK_I(bclk_pin), .BCLK_O(bclk_o),
      .BCLK_OE(bclk_oe), .LRCK_I(src_lrck), .LRCK_O(lrck_o), .LRCK_OE(lrck_oe), .DIN(din),
      .SDO_I(1'b0), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .PLL_REF_BCLK(ref_bclk),
      .PROC_CLK_SRC(src), .PROC_CLK_MUTED(muted), .OUT_VALID(out_valid),
      .OUT_DATA(out_data), .OUT_READY(out_ready), .RX_OVERRUN(overrun));
   apcd_source_model #(.WORD(WORD)) apcd_source_model_i (.BCLK(src_bclk), .LRCK(src_lrck),
      .DIN(din));
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk); #1;
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk); #1;
      req = '0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk); #1;
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk); #1;
      req = '0;
      `CHK("rvalid", 1'b1, rsp.rvalid)
      `CHK("rdata", exp, rsp.rdata)
   endtask
   // cycles between two changes of a clock output, after the next change
   task automatic meas(input logic sel, output int c);
      logic v;
      for (int k = 0; k < 2; k++) begin
         v = sel ? lrck_o : bclk_o;
         c = 0;
         while ((sel ? lrck_o : bclk_o) === v && c < 3000) begin
            @(posedge clk); #1;
            c++;
         end
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h0C, 8'h01);
      rd_chk(8'h0D, 8'h00);
      rd_chk(8'h0A, 8'h00);
      `CHK("pin dirs", 3'b000, {sdo_oe, bclk_oe, lrck_oe})
   endtask
   task automatic t_regs;
      wr(8'h08, 8'hFF);
      `CHK("sdo_oe", 1'b1, sdo_oe)
      rd_chk(8'h08, 8'h30);
      wr(8'h09, 8'hFF);
      `CHK("clk dirs", 2'b11, {bclk_oe, lrck_oe})
      rd_chk(8'h09, 8'h31);
      wr(8'h0D, 8'hFF);
      `CHK("ref", 1'b1, ref_bclk)
      rd_chk(8'h0D, 8'h17);
      auto_mode = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("auto ref", 1'b0, ref_bclk)
      auto_mode = 1'b0;
      for (int c = 0; c < 8; c++) begin
         wr(8'h0D, 8'(c));
         `CHK("src", 3'(c), src)
         `CHK("muted", c > 5, muted)
      end
      wr(8'h09, 8'h00);
      wr(8'h08, 8'h00);
      `CHK("dirs off", 3'b000, {sdo_oe, bclk_oe, lrck_oe})
   endtask
   task automatic t_mute;
      mute_req = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("mute off", 1'b0, pa_mute)
      wr(8'h08, 8'h10);
      @(posedge clk); #1;
      `CHK("mute on", 1'b1, pa_mute)
      mute_req = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("mute end", 1'b0, pa_mute)
   endtask
   task automatic t_div;
      wr(8'h0C, 8'h00);
      wr(8'h09, 8'h31);
      meas(1'b0, n);
      `CHK("held", 3000, n)
      `CHK("pol level", 1'b1, bclk_o)
      wr(8'h09, 8'h11);
      wr(8'h0C, 8'h02);
      meas(1'b0, n);
      `CHK("bclk half", 32'(bclk_half) + 1, n)
      meas(1'b1, n);
      `CHK("frame held", 3000, n)
      wr(8'h0C, 8'h03);
      meas(1'b1, n);
      `CHK("frame half", (32'(frame_half) + 1) * 2 * (32'(bclk_half) + 1), n)
   endtask
   task automatic t_stream;
      wr(8'h08, 8'h20);
      out_ready = 1'b1;
      repeat (600) @(posedge clk);
      #1;
      out_ready = 1'b0;
      n = 0;
      while (overrun !== 1'b1 && n < 2000) begin
         @(posedge clk); #1;
         n++;
      end
      `CHK("overrun", 1'b1, overrun)
      for (int k = 0; k < 2; k++) begin
         `CHK("valid", 1'b1, out_valid)
         `CHK("word", WORD, out_data)
         out_ready = 1'b1;
         @(posedge clk); #1;
         out_ready = 1'b0;
         @(posedge clk); #1;
      end
      `CHK("drained", 1'b0, out_valid)
   endtask
   // slave operation in both polarities; first frames only realign the source
   task automatic t_slave;
      for (int p = 0; p < 2; p++) begin
         s_pol = p[0];
         wr(8'h09, p ? 8'h20 : 8'h00);
         s_run = 1'b1;
         out_ready = 1'b1;
         repeat (600) @(posedge clk);
         #1;
         out_ready = 1'b0;
         n = 0;
         while (out_valid !== 1'b1 && n < 600) begin
            @(posedge clk); #1;
            n++;
         end
         `CHK("slave valid", 1'b1, out_valid)
         `CHK("slave word", WORD, out_data)
         out_ready = 1'b1;
         @(posedge clk); #1;
      end
      out_ready = 1'b0;
      s_run = 1'b0;
   endtask
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_regs();
      t_mute();
      t_div();
      t_stream();
      t_slave();
      complete_run();
   end
   // whole run needs roughly 15500 cycles
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule
bind apcd_top apcd_props #(.DATA_W(DATA_W)) apcd_props_i (.CLK(CLK), .RST(RST), .CE(CE),
   .REQ(REQ), .RSP(RSP), .AUTO_CLK_MODE(AUTO_CLK_MODE), .MUTE_REQ(MUTE_REQ),
   .PA_MUTE(PA_MUTE), .BCLK_OE(BCLK_OE), .LRCK_OE(LRCK_OE), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
   .PLL_REF_BCLK(PLL_REF_BCLK), .PROC_CLK_SRC(PROC_CLK_SRC), .PROC_CLK_MUTED(PROC_CLK_MUTED),
   .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_READY(OUT_READY), .DIN(DIN));
